// File: design/sct_pkg.sv
// Purpose: Shared constants and carriers for the stop-condition trigger block.
// Assumes: 50 MHz system clock; register port with one-cycle read latency.
// Notes: Offsets and bit positions are used by the top; offsets also by the testbench.
package sct_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    // Stop setup time (data high after clock high), nanoseconds.
    localparam int unsigned STOP_SETUP_NS = 4000;
    localparam int unsigned STOP_SETUP_CYC_I = (STOP_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [15:0] STOP_SETUP_CYC = STOP_SETUP_CYC_I[15:0];
    localparam logic [7:0] HOLD_LOW_CYC = 8'h04;
    // Register offsets.
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    // Control register bit positions.
    localparam int unsigned BIT_STOP = 0;
    localparam int unsigned BIT_START = 1;
    localparam int unsigned BIT_WSEL = 3;
    localparam int unsigned BIT_EXIT = 6;
    localparam int unsigned BIT_ENABLE = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    typedef enum logic [2:0] {
        SCT_IDLE,
        SCT_DATA_LOW,
        SCT_CLK_RELEASE,
        SCT_SETUP,
        SCT_DATA_RISE
    } sct_state_t;

    // Events from the rest of the controller.
    typedef struct packed {
        logic arb_lost;
        logic stop_detected;
        logic is_master;
        logic transmit_status_flag;
        logic ninth_clock;
    } sct_events_t;

    // Drive towards the two bus wires.
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } sct_pins_t;
endpackage

// File: design/sct_sync2.sv
// Purpose: Two-stage reset release synchroniser.
// Assumes: Active-low asynchronous reset input.
// Notes: Only the second stage is used outside.
`timescale 1ns/1ps
module sct_sync2
    import sct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    output logic rst_sync_n
);
    logic [1:0] stage_reg;

    // Assertion asynchronous, release on two clock edges.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            stage_reg <= 2'h0;
        else
            stage_reg <= {stage_reg[0], 1'b1};
    end

    assign rst_sync_n = stage_reg[1];
endmodule

// File: design/sct_timer.sv
// Purpose: Down counter that paces the stop sequence phases.
// Assumes: Load and enable are synchronous.
// Notes: Done pulses one cycle when the count reaches zero.
`timescale 1ns/1ps
module sct_timer
    import sct_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic done;
    } sct_tmr_t;
    sct_tmr_t tmr_reg;
    sct_tmr_t tmr_next;

    // Reload wins over counting so a new phase starts cleanly.
    always_comb
    begin
        tmr_next = tmr_reg;
        tmr_next.done = 1'b0;
        if (load)
            tmr_next.count = load_value;
        else if (tmr_reg.count != '0)
        begin
            tmr_next.count = tmr_reg.count - 1'b1;
            tmr_next.done = (tmr_reg.count == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            tmr_reg <= '0;
        else if (ce)
            tmr_reg <= tmr_next;
    end

    assign done = tmr_reg.done;
endmodule

// File: design/sct_stop_trigger.sv
// Purpose: Stop-condition trigger of a two-wire bus controller.
// Assumes: Software follows the set-timing limits; bus wires are open drain.
// Notes: The trigger bit reads zero; the request is held internally.
// Functional notes
// - Set trigger drives data low, then stop
// - Stop needed before first detected stop
// - Eight-clock wait gives stop in ninth high
// - Cleared by loss, stop, exit, disable, reset
// - Transmit flag: release wait, release data
// - Trigger bit reads back as zero
// - Exit is bit 6, enable bit 7
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module sct_stop_trigger
    import sct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire sct_events_t events,
    input wire logic serial_clock_line_in,
    input wire logic serial_data_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    output logic wait_release,
    output logic transmit_status_clear,
    output logic stop_busy,
    output logic start_trigger
);
    typedef struct packed {
        sct_state_t state;
        logic stop_pending;
        logic bus_unit_enable;
        logic comm_exit_request;
        logic nine_clock_wait_select;
        logic start_trigger;
        logic wait_release;
        logic transmit_status_clear;
        sct_pins_t pins;
        logic [7:0] rdata;
        logic tx_release_done;
    } sct_core_t;

    sct_core_t core_reg;
    sct_core_t core_next;
    logic rst_n;
    logic timer_load;
    logic [15:0] timer_value;
    logic timer_done;
    logic write_ctrl;
    logic clear_event;
    logic enable_write;
    logic [7:0] ctrl_view;

    sct_sync2 i_sct_sync2 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .rst_sync_n(rst_n)
    );

    sct_timer #(.WIDTH(16)) i_sct_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(clk_en),
        .load(timer_load),
        .load_value(timer_value),
        .done(timer_done)
    );

    // Clearing events; disable is a level cause, exit a one-cycle pulse after the write.
    // A write that enables the unit masks the disable cause, so enable and stop may share one write.
    assign write_ctrl = reg_write && (reg_addr == OFS_CONTROL);
    assign enable_write = write_ctrl && reg_wdata[BIT_ENABLE];
    assign clear_event = events.arb_lost || events.stop_detected || core_reg.comm_exit_request
                         || (!core_reg.bus_unit_enable && !enable_write);

    // Control view: trigger bits always read as zero after writing.
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[BIT_ENABLE] = core_reg.bus_unit_enable;
        ctrl_view[BIT_EXIT] = 1'b0;
        ctrl_view[BIT_WSEL] = core_reg.nine_clock_wait_select;
        ctrl_view[BIT_STOP] = 1'b0;
    end

    // Next-state logic for the whole block.
    always_comb
    begin
        core_next = core_reg;
        timer_load = 1'b0;
        timer_value = 16'h0000;
        core_next.wait_release = 1'b0;
        core_next.transmit_status_clear = 1'b0;
        core_next.comm_exit_request = 1'b0;
        core_next.start_trigger = 1'b0;
        // Register writes.
        if (write_ctrl)
        begin
            core_next.bus_unit_enable = reg_wdata[BIT_ENABLE];
            core_next.comm_exit_request = reg_wdata[BIT_EXIT];
            core_next.nine_clock_wait_select = reg_wdata[BIT_WSEL];
            // Start and stop in one write is illegal; stop is dropped then.
            core_next.start_trigger = reg_wdata[BIT_START];
            if (reg_wdata[BIT_STOP] && !reg_wdata[BIT_START] && reg_wdata[BIT_ENABLE]
                && !reg_wdata[BIT_EXIT] && !core_reg.stop_pending)
                core_next.stop_pending = 1'b1;
        end
        // Read data valid the cycle after the strobe only.
        core_next.rdata = 8'h00;
        if (reg_read)
        begin
            if (reg_addr == OFS_CONTROL)
                core_next.rdata = ctrl_view;
            else if (reg_addr == OFS_STATUS)
                core_next.rdata = {5'h00, core_reg.stop_pending, events.is_master,
                                   core_reg.state != SCT_IDLE};
        end
        // Transmitter release on the ninth clock, once per ninth clock.
        if (events.transmit_status_flag && events.ninth_clock && !core_reg.tx_release_done)
        begin
            core_next.wait_release = 1'b1;
            core_next.transmit_status_clear = 1'b1;
            core_next.pins.sda_oe = 1'b0;
            core_next.tx_release_done = 1'b1;
        end
        if (!events.ninth_clock)
            core_next.tx_release_done = 1'b0;
        // Stop sequence.
        case (core_reg.state)
            SCT_IDLE:
            begin
                if (core_reg.stop_pending && events.is_master)
                begin
                    // The clock is pulled low in the same cycle as the data, so the data fall is not read as a start.
                    core_next.pins.scl_oe = 1'b1;
                    core_next.pins.sda_oe = 1'b1;
                    timer_load = 1'b1;
                    timer_value = {8'h00, HOLD_LOW_CYC};
                    core_next.state = SCT_DATA_LOW;
                end
            end
            SCT_DATA_LOW:
            begin
                if (timer_done)
                begin
                    core_next.pins.scl_oe = 1'b0;
                    core_next.state = SCT_CLK_RELEASE;
                end
            end
            SCT_CLK_RELEASE:
            begin
                // Wait for the wire, a slave may stretch the clock.
                // After an eight-clock wait this released clock is the ninth, so the stop lands in its high phase.
                if (serial_clock_line_in)
                begin
                    timer_load = 1'b1;
                    timer_value = STOP_SETUP_CYC;
                    core_next.state = SCT_SETUP;
                end
            end
            SCT_SETUP:
            begin
                if (timer_done)
                begin
                    core_next.pins.sda_oe = 1'b0;
                    core_next.state = SCT_DATA_RISE;
                end
            end
            SCT_DATA_RISE:
            begin
                // The stop completes once the data wire is seen high.
                if (serial_data_line_in)
                begin
                    core_next.stop_pending = 1'b0;
                    core_next.state = SCT_IDLE;
                end
            end
            default:
                core_next.state = SCT_IDLE;
        endcase
        // Clearing events abort any sequence and release the wires; they win over a same-cycle set.
        if (clear_event)
        begin
            core_next.stop_pending = 1'b0;
            core_next.state = SCT_IDLE;
            core_next.pins = '0;
        end
    end

    // Single state register frozen while the clock enable is low.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_reg <= '0;
            core_reg.state <= SCT_IDLE;
        end
        else if (clk_en)
            core_reg <= core_next;
    end

    // Open-drain wires only ever pull low.
    assign serial_clock_line_out = 1'b0;
    assign serial_data_line_out = 1'b0;
    assign serial_clock_line_oe = core_reg.pins.scl_oe;
    assign serial_data_line_oe = core_reg.pins.sda_oe;
    assign reg_rdata = core_reg.rdata;
    assign wait_release = core_reg.wait_release;
    assign transmit_status_clear = core_reg.transmit_status_clear;
    assign stop_busy = core_reg.stop_pending;
    assign start_trigger = core_reg.start_trigger;

    chk_trigger_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && reg_read && reg_addr == OFS_CONTROL |=> reg_rdata[BIT_STOP] == 1'b0)
        else $error("Stop trigger read back nonzero.");
    chk_disable_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && !core_reg.bus_unit_enable && !write_ctrl |=> !stop_busy)
        else $error("Stop request survived disabled unit.");
    chk_arb_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && events.arb_lost |=> !stop_busy)
        else $error("Stop request survived arbitration loss.");
    chk_detect_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && events.stop_detected |=> !stop_busy)
        else $error("Stop request survived a detected stop.");
    chk_exit_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && core_reg.comm_exit_request |=> !stop_busy)
        else $error("Stop request survived an exit request.");
    chk_data_low_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_reg.state == SCT_DATA_LOW) |-> serial_data_line_oe)
        else $error("Data wire not pulled low at stop start.");
    chk_clock_low_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_reg.state == SCT_DATA_LOW) |-> serial_clock_line_oe)
        else $error("Clock wire not held low at stop start.");
    chk_setup_before_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_reg.state == SCT_SETUP) |-> serial_data_line_oe && !serial_clock_line_oe)
        else $error("Setup phase entered with wrong wire drive.");
    chk_tx_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wait_release |-> transmit_status_clear && !serial_data_line_oe)
        else $error("Wait release without data release.");
    chk_release_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && wait_release |=> !wait_release)
        else $error("Wait release longer than one cycle.");
    chk_start_refuses_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && write_ctrl && reg_wdata[BIT_START] && !stop_busy |=> !stop_busy)
        else $error("Stop request taken together with start.");
    chk_hold_until_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(stop_busy) |-> $past(core_reg.state) == SCT_DATA_RISE || $past(clear_event))
        else $error("Stop request dropped without cause.");
    chk_master_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && core_reg.state == SCT_IDLE && stop_busy && !events.is_master && !clear_event
        |=> core_reg.state == SCT_IDLE)
        else $error("Stop started while not master.");
    // Scenarios worth seeing at least once: full stop, release, abort and a stop seen on the bus.
    cov_stop_done: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(stop_busy));
    cov_detect_clear: cover property (@(posedge clk_sys) disable iff (!rst_n) stop_busy && events.stop_detected);
    cov_tx_release: cover property (@(posedge clk_sys) disable iff (!rst_n) wait_release);
    cov_abort: cover property (@(posedge clk_sys) disable iff (!rst_n) stop_busy && events.arb_lost);
endmodule

// File: tb/sct_bus_partner.sv
// Purpose: Far-side model: wire pull-ups and a slow slave that stretches the clock.
// Assumes: Both wires are open drain, so a released wire floats high.
// Notes: The stretch starts when the block first pulls the data wire low.
`timescale 1ns/1ps
module sct_bus_partner
    import sct_pkg::*;
#(
    parameter int STRETCH = 30
)
(
    input wire logic clk_sys,
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    int hold_cnt = 0;
    logic sda_oe_d = 1'b0;
    // A slow slave keeps the clock low after data falls, so the block has to wait for the wire.
    always @(posedge clk_sys)
    begin
        sda_oe_d <= sda_oe;
        if (sda_oe && !sda_oe_d)
            hold_cnt <= STRETCH;
        else if (hold_cnt > 0)
            hold_cnt <= hold_cnt - 1;
    end
    // Pull-ups win only while no party pulls the wire low.
    assign scl = !(scl_oe || hold_cnt > 0);
    assign sda = !sda_oe;
endmodule

// File: tb/test_sct_stop_trigger.sv
// Purpose: Self-checking bench for the stop-condition trigger.
// Assumes: Register port with one-cycle read latency; clk_en held high.
// Notes: Expected values come from the control bit layout and the stop setup count.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_sct_stop_trigger;
    import sct_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    sct_events_t ev = '0;
    logic scl, sda, scl_out, scl_oe, sda_out, sda_oe, wait_release, ts_clear, stop_busy, start_trigger;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    logic [7:0] rd;
    sct_stop_trigger i_sct_stop_trigger (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .events(ev), .serial_clock_line_in(scl), .serial_data_line_in(sda),
        .serial_clock_line_out(scl_out), .serial_clock_line_oe(scl_oe), .serial_data_line_out(sda_out),
        .serial_data_line_oe(sda_oe), .wait_release(wait_release), .transmit_status_clear(ts_clear),
        .stop_busy(stop_busy), .start_trigger(start_trigger));
    sct_bus_partner i_sct_bus_partner (.clk_sys(clk_sys), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl(scl), .sda(sda));
    // Clock of 50 MHz.
    always #10 clk_sys = ~clk_sys;
    // Cuts a hang short; the whole run needs well under a thousand cycles.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done();
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
    task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        ev.is_master <= 1'b1;
        cyc(3);
        rdreg(OFS_CONTROL, rd);
        `CHK("control reset", CONTROL_RESET, rd)
        rdreg(OFS_STATUS, rd);
        `CHK("status idle", 8'h02, rd)
        rdreg(4'h8, rd);
        `CHK("unmapped read", 8'h00, rd)
        // Full stop sequence against a slave that stretches the clock.
        wr(OFS_CONTROL, 8'h89);
        cyc(1);
        `CHK("busy after set", 1'b1, stop_busy)
        rdreg(OFS_CONTROL, rd);
        `CHK("trigger readback", 8'h88, rd)
        n = 0;
        while (sda_oe !== 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        `CHK("data pulled low", 1'b1, sda_oe)
        `CHK("data drive level", 1'b0, sda_out)
        `CHK("clock held low", 1'b1, scl_oe)
        `CHK("clock drive level", 1'b0, scl_out)
        while (scl !== 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        `CHK("data held over stretch", 1'b1, sda_oe)
        `CHK("clock released", 1'b0, scl_oe)
        n = 0;
        while (sda_oe !== 1'b0 && n < 400)
        begin
            cyc(1);
            n++;
        end
        `CHK("setup not short", 1'b1, n >= int'(STOP_SETUP_CYC) - 1)
        `CHK("setup not long", 1'b1, n <= int'(STOP_SETUP_CYC) + 6)
        cyc(4);
        `CHK("busy after stop", 1'b0, stop_busy)
        // Start together with stop is refused, and start still pulses.
        // The pulse stands from the write edge to the next one, so it is looked at just past the write edge.
        wr(OFS_CONTROL, 8'h83);
        #1;
        `CHK("start pulse", 1'b1, start_trigger)
        cyc(1);
        `CHK("start pulse ends", 1'b0, start_trigger)
        cyc(1);
        `CHK("stop with start", 1'b0, stop_busy)
        // Stop while disabled or with exit set is refused.
        wr(OFS_CONTROL, 8'h01);
        cyc(2);
        `CHK("stop disabled", 1'b0, stop_busy)
        wr(OFS_CONTROL, 8'hc1);
        cyc(2);
        `CHK("stop with exit", 1'b0, stop_busy)
        // Each clearing event drops a held request: loss, exit, disable, detected stop.
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_CONTROL, 8'h81);
            cyc(2);
            `CHK("busy before clear", 1'b1, stop_busy)
            if (k == 0 || k == 3)
            begin
                ev.arb_lost <= (k == 0);
                ev.stop_detected <= (k == 3);
                cyc(1);
                ev.arb_lost <= 1'b0;
                ev.stop_detected <= 1'b0;
            end
            else
                wr(OFS_CONTROL, (k == 1) ? 8'hc0 : 8'h00);
            cyc(3);
            `CHK("cleared by event", 1'b0, stop_busy)
        end
        // Reset in mid-sequence clears the request and all drive.
        wr(OFS_CONTROL, 8'h81);
        cyc(3);
        reset_n <= 1'b0;
        cyc(2);
        `CHK("busy in reset", 1'b0, stop_busy)
        `CHK("data in reset", 1'b0, sda_oe)
        reset_n <= 1'b1;
        cyc(4);
        // Transmit status: ninth clock releases the wait and clears the flag.
        ev.transmit_status_flag <= 1'b1;
        ev.ninth_clock <= 1'b1;
        cyc(1);
        ev.ninth_clock <= 1'b0;
        n = 0;
        while (wait_release !== 1'b1 && n < 10)
        begin
            cyc(1);
            n++;
        end
        `CHK("wait release", 1'b1, wait_release)
        `CHK("transmit clear", 1'b1, ts_clear)
        `CHK("data released", 1'b0, sda_oe)
        ev.transmit_status_flag <= 1'b0;
        cyc(2);
        `CHK("release one cycle", 1'b0, wait_release)
        test_done();
    end
endmodule
